/* rtl/dcd_device.sv */
// Device end: decodes link commands and tracks bank, burst, calibration and power state.
// Assumes the link pins are asynchronous to clk and the link clock is well below clk/4.
//
// Behaviour
// - Controller keeps reset pin high in operation.
// - Termination input never affects decoding.
// - Mode set writes register chosen by bank.
// - Self refresh exits without a clock edge.
// - Started bursts always complete, never interrupted.
// - No-operation registers nothing, stops nothing.
// - Deselect ignores commands, acts as no-operation.
// - No refresh runs while powered down.
// - Clock enable judged as previous/present pair.
// - Falling enable enters power-down or self refresh.
// - Controller drives only defined state combinations.
// - Controller holds new enable several edges.
// - Idle needs closed banks, no bursts, timings.
// - Long calibration runs engine, then updates I/O.
// - Controller waits init or operational calibration window.
// - Short calibration finishes within 64 cycles.
// - Activate opens addressed row in selected bank.
// - Controller precharges before opening another row.
// - Read low address bits give start column.
// - Read bit 10 selects auto precharge.
// - On-the-fly mode lets bit 12 pick burst.
// - Commands decoded from strobes at clock rise.
`timescale 1ns/100ps
module dcd_device import dcd_pkg::*; (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  dcd_if.dev                         bus,
  output dcd_pwr_t                   pwr_state,
  output logic                       pd_active,
  output logic [NBANK-1:0]           bank_open,
  output logic                       idle,
  output logic                       burst_busy,
  output logic                       rd_start,
  output logic [BA_W-1:0]            rd_bank,
  output logic [2:0]                 rd_col,
  output logic                       rd_bc4,
  output logic                       rd_ap,
  output logic                       zq_busy,
  output logic                       zq_update,
  output logic [NMR*ADDR_W-1:0]      mode_regs
);
  // Pin vector positions.
  localparam int P_CK  = PIN_W - 1;
  localparam int P_CKE = PIN_W - 2;
  localparam int P_CS  = PIN_W - 3;
  localparam int P_CMD = PIN_W - 4;

  // Either the local reset or the reset pin clears the device at once.
  wire arst_n = rstn & bus.reset_n;

  logic [PIN_W-1:0]  s1_r, s1_nxt, s2_r, s2_nxt, s3_r, s3_nxt;
  logic              cke_prev_r, cke_prev_nxt;
  dcd_pwr_t          pwr_r, pwr_nxt;
  logic              pd_active_r, pd_active_nxt;
  logic [NBANK-1:0]  bank_open_r, bank_open_nxt;
  logic [ADDR_W-1:0] row_r [NBANK];
  logic [ADDR_W-1:0] row_nxt [NBANK];
  logic [ADDR_W-1:0] mr_r [NMR];
  logic [ADDR_W-1:0] mr_nxt [NMR];
  logic [2:0]        burst_cnt_r, burst_cnt_nxt;
  logic [BA_W-1:0]   rd_bank_r, rd_bank_nxt;
  logic [2:0]        rd_col_r, rd_col_nxt;
  logic              rd_bc4_r, rd_bc4_nxt;
  logic              rd_ap_r, rd_ap_nxt;
  logic              rd_start_r, rd_start_nxt;
  logic [CNT_W-1:0]  zq_cnt_r, zq_cnt_nxt;
  logic              zq_update_r, zq_update_nxt;
  logic [1:0]        xp_cnt_r, xp_cnt_nxt;
  logic              idle_r, idle_nxt;

  // Decoded view of the second synchroniser stage; the first stage feeds nothing else.
  logic              ck_rise;
  logic              cke_n;
  logic              is_nop;
  logic [2:0]        pin_cmd;
  logic [BA_W-1:0]   pin_ba;
  logic [ADDR_W-1:0] pin_addr;
  logic              otf_bc4;

  assign ck_rise  = s2_r[P_CK] & ~s3_r[P_CK];
  assign cke_n    = s2_r[P_CKE];
  assign pin_cmd  = s2_r[P_CMD -: 3];
  assign pin_ba   = s2_r[ADDR_W +: BA_W];
  assign pin_addr = s2_r[ADDR_W-1:0];
  // Deselect and no-operation share one decode, and odt is never sampled.
  assign is_nop   = s2_r[P_CS] | (pin_cmd == PIN_NOP);

  // Burst length: fixed by mode register 0 unless on-the-fly selection is on.
  always_comb
  begin
    case (mr_r[0][MR0_BL_LSB +: 2])
      BL_OTF:  otf_bc4 = ~pin_addr[A_BC];
      BL_FIX4: otf_bc4 = 1'b1;
      default: otf_bc4 = 1'b0;
    endcase
  end

  // Next state of the whole device, evaluated every system clock; most state moves only on a sampled link clock rise.
  always_comb
  begin
    s1_nxt        = {bus.ck, bus.cke, bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n, bus.ba, bus.addr};
    s2_nxt        = s1_r;
    s3_nxt        = s2_r;
    cke_prev_nxt  = cke_prev_r;
    pwr_nxt       = pwr_r;
    pd_active_nxt = pd_active_r;
    bank_open_nxt = bank_open_r;
    row_nxt       = row_r;
    mr_nxt        = mr_r;
    burst_cnt_nxt = burst_cnt_r;
    rd_bank_nxt   = rd_bank_r;
    rd_col_nxt    = rd_col_r;
    rd_bc4_nxt    = rd_bc4_r;
    rd_ap_nxt     = rd_ap_r;
    rd_start_nxt  = 1'b0;
    zq_cnt_nxt    = zq_cnt_r;
    zq_update_nxt = 1'b0;
    xp_cnt_nxt    = xp_cnt_r;
    if ((pwr_r == DCD_PWR_SR) && cke_n)
    begin
      // The exit is taken on the enable level alone, since the clock may still be stopped.
      pwr_nxt      = DCD_PWR_ACT;
      cke_prev_nxt = 1'b1;
      xp_cnt_nxt   = 2'(XP_CK);
    end
    else if (ck_rise)
    begin
      cke_prev_nxt = cke_n;
      // A running burst counts down whatever arrives meanwhile.
      if (burst_cnt_r != 3'h0)
      begin
        burst_cnt_nxt = burst_cnt_r - 3'h1;
        if ((burst_cnt_r == 3'h1) && rd_ap_r)
          bank_open_nxt[rd_bank_r] = 1'b0;
      end
      if (zq_cnt_r != {CNT_W{1'b0}})
      begin
        zq_cnt_nxt = zq_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        if (zq_cnt_r == {{(CNT_W-1){1'b0}}, 1'b1})
          zq_update_nxt = 1'b1;
      end
      if (xp_cnt_r != 2'h0)
        xp_cnt_nxt = xp_cnt_r - 2'h1;
      case (pwr_r)
        DCD_PWR_PD:
        begin
          // Low-low keeps power-down; no refresh is started here.
          if (!cke_prev_r && cke_n && is_nop)
          begin
            pwr_nxt    = DCD_PWR_ACT;
            xp_cnt_nxt = 2'(XP_CK);
          end
        end
        DCD_PWR_ACT:
        begin
          if (cke_prev_r && !cke_n)
          begin
            if (is_nop)
            begin
              pwr_nxt       = DCD_PWR_PD;
              pd_active_nxt = |bank_open_r;
            end
            else if ((pin_cmd == PIN_REF) && (bank_open_r == {NBANK{1'b0}}) && (burst_cnt_r == 3'h0))
              pwr_nxt = DCD_PWR_SR;
          end
          else if (cke_prev_r && cke_n && !is_nop)
          begin
            case (pin_cmd)
              PIN_MRS: mr_nxt[pin_ba[1:0]] = pin_addr;
              PIN_ACT:
              begin
                if (!bank_open_r[pin_ba])
                begin
                  bank_open_nxt[pin_ba] = 1'b1;
                  row_nxt[pin_ba]       = pin_addr;
                end
              end
              PIN_PRE:
              begin
                if (pin_addr[A_AP])
                  bank_open_nxt = {NBANK{1'b0}};
                else
                  bank_open_nxt[pin_ba] = 1'b0;
              end
              PIN_RD:
              begin
                // A read to a closed bank or during a burst is dropped.
                if (bank_open_r[pin_ba] && (burst_cnt_r == 3'h0))
                begin
                  rd_bank_nxt   = pin_ba;
                  rd_col_nxt    = pin_addr[2:0];
                  rd_ap_nxt     = pin_addr[A_AP];
                  rd_bc4_nxt    = otf_bc4;
                  burst_cnt_nxt = otf_bc4 ? 3'(BC4_CK) : 3'(BL8_CK);
                  rd_start_nxt  = 1'b1;
                end
              end
              PIN_ZQ:
              begin
                if (zq_cnt_r == {CNT_W{1'b0}})
                  zq_cnt_nxt = pin_addr[A_AP] ? CNT_W'(ZQOPER_CK) : CNT_W'(ZQCS_CK);
              end
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end
    idle_nxt = (pwr_r == DCD_PWR_ACT) && (bank_open_r == {NBANK{1'b0}}) && (burst_cnt_r == 3'h0)
               && cke_prev_r && (xp_cnt_r == 2'h0) && (zq_cnt_r == {CNT_W{1'b0}});
  end

  // Registers only; every value above is computed in the process before.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r        <= '0;
      s2_r        <= '0;
      s3_r        <= '0;
      cke_prev_r  <= 1'b0;
      pwr_r       <= DCD_PWR_ACT;
      pd_active_r <= 1'b0;
      bank_open_r <= '0;
      row_r       <= '{default: '0};
      mr_r        <= '{default: '0};
      burst_cnt_r <= 3'h0;
      rd_bank_r   <= '0;
      rd_col_r    <= 3'h0;
      rd_bc4_r    <= 1'b0;
      rd_ap_r     <= 1'b0;
      rd_start_r  <= 1'b0;
      zq_cnt_r    <= '0;
      zq_update_r <= 1'b0;
      xp_cnt_r    <= 2'h0;
      idle_r      <= 1'b0;
    end
    else
    begin
      s1_r        <= s1_nxt;
      s2_r        <= s2_nxt;
      s3_r        <= s3_nxt;
      cke_prev_r  <= cke_prev_nxt;
      pwr_r       <= pwr_nxt;
      pd_active_r <= pd_active_nxt;
      bank_open_r <= bank_open_nxt;
      row_r       <= row_nxt;
      mr_r        <= mr_nxt;
      burst_cnt_r <= burst_cnt_nxt;
      rd_bank_r   <= rd_bank_nxt;
      rd_col_r    <= rd_col_nxt;
      rd_bc4_r    <= rd_bc4_nxt;
      rd_ap_r     <= rd_ap_nxt;
      rd_start_r  <= rd_start_nxt;
      zq_cnt_r    <= zq_cnt_nxt;
      zq_update_r <= zq_update_nxt;
      xp_cnt_r    <= xp_cnt_nxt;
      idle_r      <= idle_nxt;
    end
  end

  // Mode registers are flattened, register 0 in the low bits.
  for (genvar i = 0; i < NMR; i++)
  begin : g_mr
    assign mode_regs[i*ADDR_W +: ADDR_W] = mr_r[i];
  end

  assign pwr_state  = pwr_r;
  assign pd_active  = pd_active_r;
  assign bank_open  = bank_open_r;
  assign idle       = idle_r;
  assign burst_busy = (burst_cnt_r != 3'h0);
  assign rd_start   = rd_start_r;
  assign rd_bank    = rd_bank_r;
  assign rd_col     = rd_col_r;
  assign rd_bc4     = rd_bc4_r;
  assign rd_ap      = rd_ap_r;
  assign zq_busy    = (zq_cnt_r != {CNT_W{1'b0}});
  assign zq_update  = zq_update_r;
endmodule : dcd_device

/* common/dcd_pkg.sv */
// Shared constants and types for the command and clock-enable decoder pair.
// Assumes both ends are clocked by the same 100 MHz system clock; counts are in link clock cycles.
package dcd_pkg;
  localparam int BA_W       = 3;
  localparam int ADDR_W     = 14;
  localparam int NBANK      = 8;
  localparam int NMR        = 4;
  localparam int PIN_W      = 6 + BA_W + ADDR_W;
  localparam int CNT_W      = 10;
  // Link clock period as a count of system clocks (80 ns at 10 ns).
  localparam int CK_DIV     = 8;
  // Timing windows, in link clock cycles.
  localparam int CKE_MIN_CK = 3;
  localparam int XP_CK      = 3;
  localparam int ZQCS_CK    = 64;
  localparam int ZQOPER_CK  = 256;
  localparam int ZQINIT_CK  = 512;
  localparam int BL8_CK     = 4;
  localparam int BC4_CK     = 2;
  // Address bit positions and mode register 0 burst field.
  localparam int A_AP       = 10;
  localparam int A_BC       = 12;
  localparam int MR0_BL_LSB = 0;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  // Row, column and write strobe levels {ras_n, cas_n, we_n} with chip select low.
  localparam logic [2:0] PIN_MRS = 3'h0;
  localparam logic [2:0] PIN_REF = 3'h1;
  localparam logic [2:0] PIN_PRE = 3'h2;
  localparam logic [2:0] PIN_ACT = 3'h3;
  localparam logic [2:0] PIN_RD  = 3'h5;
  localparam logic [2:0] PIN_ZQ  = 3'h6;
  localparam logic [2:0] PIN_NOP = 3'h7;

  typedef enum logic [1:0] {
    DCD_PWR_ACT = 2'h0,
    DCD_PWR_PD  = 2'h1,
    DCD_PWR_SR  = 2'h3
  } dcd_pwr_t;

  typedef enum logic [3:0] {
    CMD_NOP  = 4'h0,
    CMD_MRS  = 4'h1,
    CMD_REF  = 4'h2,
    CMD_PRE  = 4'h3,
    CMD_PREA = 4'h4,
    CMD_ACT  = 4'h5,
    CMD_RD   = 4'h6,
    CMD_ZQCL = 4'h7,
    CMD_ZQCS = 4'h8,
    CMD_PDE  = 4'h9,
    CMD_PDX  = 4'ha,
    CMD_SRE  = 4'hb,
    CMD_SRX  = 4'hc
  } dcd_cmd_t;
endpackage : dcd_pkg

/* common/dcd_if.sv */
// Link between the memory controller end and the memory device end.
// Assumes the controller drives every signal; the device only samples them.
`timescale 1ns/100ps
interface dcd_if import dcd_pkg::*;;
  logic              ck;
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic              reset_n;
  logic              odt;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;

  modport dev  (input ck, cke, cs_n, ras_n, cas_n, we_n, reset_n, odt, ba, addr);
  modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, reset_n, odt, ba, addr);
endinterface : dcd_if

/* rtl/dcd_ctrl.sv */
// Controller end: makes the link clock and issues checked commands with their waits.
// Assumes one request at a time from a user that watches req_ready.
`timescale 1ns/100ps
module dcd_ctrl import dcd_pkg::*; #(
  parameter int CLK_DIV = CK_DIV
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  dcd_if.ctrl                    bus,
  input  wire logic              req_valid,
  input  wire dcd_cmd_t          req_cmd,
  input  wire logic [BA_W-1:0]   req_ba,
  input  wire logic [ADDR_W-1:0] req_addr,
  output logic                   req_ready,
  output logic                   req_error,
  output dcd_pwr_t               pwr_state,
  output logic [NBANK-1:0]       banks_open
);
  if ((CLK_DIV < 4) || (CLK_DIV % 2 != 0))
  begin : g_chk
    $error("CLK_DIV must be even and at least 4");
  end

  localparam logic [7:0] HALF = 8'(CLK_DIV / 2 - 1);

  logic [7:0]        div_r, div_nxt;
  logic              ck_r, ck_nxt, rst_out_r, rst_out_nxt;
  logic              pend_r, pend_nxt, err_r, err_nxt, zq_init_r, zq_init_nxt;
  dcd_cmd_t          cmd_r, cmd_nxt;
  logic [BA_W-1:0]   ba_r, ba_nxt, pba_r, pba_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt, paddr_r, paddr_nxt;
  logic              cke_r, cke_nxt, cs_r, cs_nxt;
  logic [2:0]        pin_r, pin_nxt;
  logic [CNT_W-1:0]  wait_r, wait_nxt;
  dcd_pwr_t          pwr_r, pwr_nxt;
  logic [NBANK-1:0]  open_r, open_nxt;
  logic              tick, legal;

  assign tick = (div_r == HALF);

  // Only combinations the device defines are sent; the rest is refused at once.
  always_comb
  begin
    case (req_cmd)
      CMD_PDX:  legal = (pwr_r == DCD_PWR_PD);
      CMD_SRX:  legal = (pwr_r == DCD_PWR_SR);
      CMD_SRE:  legal = (pwr_r == DCD_PWR_ACT) && (open_r == {NBANK{1'b0}});
      CMD_ACT:  legal = (pwr_r == DCD_PWR_ACT) && !open_r[req_ba];
      CMD_RD:   legal = (pwr_r == DCD_PWR_ACT) && open_r[req_ba];
      // Refresh is never sent in power-down; the user schedules it around those periods.
      default:  legal = (pwr_r == DCD_PWR_ACT);
    endcase
  end

  // Divider, request capture and pin drive; pins change on the link clock fall.
  always_comb
  begin
    div_nxt     = tick ? 8'h00 : div_r + 8'h01;
    ck_nxt      = tick ? ~ck_r : ck_r;
    rst_out_nxt = 1'b1;
    pend_nxt    = pend_r;
    err_nxt     = 1'b0;
    zq_init_nxt = zq_init_r;
    cmd_nxt     = cmd_r;
    pba_nxt     = pba_r;
    paddr_nxt   = paddr_r;
    ba_nxt      = ba_r;
    addr_nxt    = addr_r;
    cke_nxt     = cke_r;
    cs_nxt      = cs_r;
    pin_nxt     = pin_r;
    wait_nxt    = wait_r;
    pwr_nxt     = pwr_r;
    open_nxt    = open_r;
    if (req_valid && req_ready)
    begin
      pend_nxt  = legal;
      err_nxt   = ~legal;
      cmd_nxt   = req_cmd;
      pba_nxt   = req_ba;
      paddr_nxt = req_addr;
    end
    if (tick && !ck_r && (wait_r != {CNT_W{1'b0}}))
      wait_nxt = wait_r - {{(CNT_W-1){1'b0}}, 1'b1};
    if (tick && ck_r)
    begin
      cs_nxt  = 1'b1;
      pin_nxt = PIN_NOP;
      if (pend_r)
      begin
        pend_nxt = 1'b0;
        ba_nxt   = pba_r;
        addr_nxt = paddr_r;
        cs_nxt   = 1'b0;
        wait_nxt = {{(CNT_W-1){1'b0}}, 1'b1};
        case (cmd_r)
          CMD_MRS:  pin_nxt = PIN_MRS;
          CMD_REF:  pin_nxt = PIN_REF;
          CMD_PRE:  begin pin_nxt = PIN_PRE; addr_nxt[A_AP] = 1'b0; open_nxt[pba_r] = 1'b0; end
          CMD_PREA: begin pin_nxt = PIN_PRE; addr_nxt[A_AP] = 1'b1; open_nxt = '0; end
          CMD_ACT:  begin pin_nxt = PIN_ACT; open_nxt[pba_r] = 1'b1; end
          CMD_RD:
          begin
            // The next command waits out a whole BL8 burst plus one link clock, since the device
            // still counts its last burst beat on the rise that would otherwise take it.
            pin_nxt  = PIN_RD;
            wait_nxt = CNT_W'(BL8_CK + 1);
            if (paddr_r[A_AP])
              open_nxt[pba_r] = 1'b0;
          end
          CMD_ZQCL:
          begin
            pin_nxt = PIN_ZQ;
            addr_nxt[A_AP] = 1'b1;
            wait_nxt = zq_init_r ? CNT_W'(ZQOPER_CK + 1) : CNT_W'(ZQINIT_CK);
            zq_init_nxt = 1'b1;
          end
          CMD_ZQCS: begin pin_nxt = PIN_ZQ; addr_nxt[A_AP] = 1'b0; wait_nxt = CNT_W'(ZQCS_CK + 1); end
          CMD_PDE:  begin cs_nxt = 1'b1; cke_nxt = 1'b0; pwr_nxt = DCD_PWR_PD; end
          CMD_SRE:  begin pin_nxt = PIN_REF; cke_nxt = 1'b0; pwr_nxt = DCD_PWR_SR; end
          CMD_PDX,
          CMD_SRX:  begin cs_nxt = 1'b1; cke_nxt = 1'b1; pwr_nxt = DCD_PWR_ACT; end
          default:  pin_nxt = PIN_NOP;
        endcase
        // Any enable change is held for the minimum pulse plus the exit time before another command.
        if (cke_nxt != cke_r)
          wait_nxt = CNT_W'(CKE_MIN_CK + XP_CK);
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_r     <= 8'h00;
      ck_r      <= 1'b0;
      rst_out_r <= 1'b0;
      pend_r    <= 1'b0;
      err_r     <= 1'b0;
      zq_init_r <= 1'b0;
      cmd_r     <= CMD_NOP;
      pba_r     <= '0;
      paddr_r   <= '0;
      ba_r      <= '0;
      addr_r    <= '0;
      cke_r     <= 1'b1;
      cs_r      <= 1'b1;
      pin_r     <= PIN_NOP;
      wait_r    <= '0;
      pwr_r     <= DCD_PWR_ACT;
      open_r    <= '0;
    end
    else
    begin
      div_r     <= div_nxt;
      ck_r      <= ck_nxt;
      rst_out_r <= rst_out_nxt;
      pend_r    <= pend_nxt;
      err_r     <= err_nxt;
      zq_init_r <= zq_init_nxt;
      cmd_r     <= cmd_nxt;
      pba_r     <= pba_nxt;
      paddr_r   <= paddr_nxt;
      ba_r      <= ba_nxt;
      addr_r    <= addr_nxt;
      cke_r     <= cke_nxt;
      cs_r      <= cs_nxt;
      pin_r     <= pin_nxt;
      wait_r    <= wait_nxt;
      pwr_r     <= pwr_nxt;
      open_r    <= open_nxt;
    end
  end

  assign req_ready   = ~pend_r & (wait_r == {CNT_W{1'b0}});
  assign req_error   = err_r;
  assign pwr_state   = pwr_r;
  assign banks_open  = open_r;
  assign bus.ck      = ck_r;
  assign bus.cke     = cke_r;
  assign bus.cs_n    = cs_r;
  assign {bus.ras_n, bus.cas_n, bus.we_n} = pin_r;
  assign bus.ba      = ba_r;
  assign bus.addr    = addr_r;
  assign bus.reset_n = rst_out_r;
  assign bus.odt     = 1'b0;
endmodule : dcd_ctrl

/* verif/dcd_monitor.sv */
// Concurrent checks on the link between controller end and device end.
// Assumes it sits beside the dcd_if instance and shares the system clock and reset.
`timescale 1ns/100ps
module dcd_monitor import dcd_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic odt
);
  // One clock domain, so clocking and disable are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic [2:0] strb = {ras_n, cas_n, we_n};

  // The device reset pin must stay high once the controller is out of reset.
  chk_reset_pin_high: assert property ($past(rstn) |-> reset_n)
    else $error("device reset pin low in operation");
  chk_odt_tied_low: assert property (!odt)
    else $error("termination pin driven high");
  // Half period of the link clock is CK_DIV/2 system clocks.
  chk_ck_duty: assert property ($rose(ck) |-> ck[*4] ##1 !ck)
    else $error("link clock high phase wrong");
  chk_pins_at_fall: assert property (($changed(cs_n) || $changed(cke)) |-> $fell(ck))
    else $error("link pins moved away from a clock fall");
  chk_cmd_whole_ck: assert property ($fell(cs_n) |-> !cs_n[*8])
    else $error("command held less than one link clock");
  // A started burst is never followed closely by another command.
  chk_rd_no_cut: assert property ($fell(cs_n) && strb == PIN_RD |-> ##8 cs_n[*8] ##1 cs_n[*8])
    else $error("command issued inside a read burst");
  // The entry command itself stands for one link clock after the enable falls, so it is exempt.
  chk_pd_no_cmd: assert property (!cke && !$past(cke, 8) |-> cs_n || strb == PIN_NOP)
    else $error("command while clock enable low");
  chk_cke_hold: assert property ($changed(cke) |=> $stable(cke)[*8])
    else $error("clock enable not held after a change");
  chk_sre_refresh: assert property ($fell(cke) && !cs_n |-> strb == PIN_REF)
    else $error("clock enable fell with a selected non-refresh command");
endmodule : dcd_monitor

/* verif/dcd_tb.sv */
// Self-checking bench joining the controller end to the device end.
// Assumes the user side of the controller drives all traffic; the device is only observed.
`timescale 1ns/100ps
module dcd_tb import dcd_pkg::*;;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              req_valid = 1'b0;
  dcd_cmd_t          req_cmd = CMD_NOP;
  logic [BA_W-1:0]   req_ba = 3'h0;
  logic [ADDR_W-1:0] req_addr = 14'h0000;
  logic              req_ready, req_error, pd_active, idle, burst_busy, rd_start;
  logic              rd_bc4, rd_ap, zq_busy, zq_update, err, zq_prev;
  dcd_pwr_t          pwr_state, c_pwr;
  logic [NBANK-1:0]  bank_open, c_banks;
  logic [BA_W-1:0]   rd_bank;
  logic [2:0]        rd_col;
  logic [NMR*ADDR_W-1:0] mode_regs;
  int                n_mismatch = 0, n_tests = 0, n_cyc = 0, n_zqu = 0, busy_len = 0, zq_len = 0;

  dcd_if link ();
  dcd_ctrl #(.CLK_DIV(CK_DIV)) i_dcd_ctrl (.clk(clk), .rstn(rstn), .bus(link), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr), .req_ready(req_ready),
    .req_error(req_error), .pwr_state(c_pwr), .banks_open(c_banks));
  dcd_device i_dcd_device (.clk(clk), .rstn(rstn), .bus(link), .pwr_state(pwr_state), .pd_active(pd_active),
    .bank_open(bank_open), .idle(idle), .burst_busy(burst_busy), .rd_start(rd_start), .rd_bank(rd_bank),
    .rd_col(rd_col), .rd_bc4(rd_bc4), .rd_ap(rd_ap), .zq_busy(zq_busy), .zq_update(zq_update),
    .mode_regs(mode_regs));
  dcd_monitor i_dcd_monitor (.clk(clk), .rstn(rstn), .ck(link.ck), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .reset_n(link.reset_n), .odt(link.odt));

  always #5 clk = ~clk;

  // Burst and calibration lengths measured at the device, plus a hang limit.
  always @(posedge clk)
  begin
    n_cyc <= n_cyc + 1;
    zq_prev <= zq_busy;
    busy_len <= rd_start ? 0 : busy_len + int'(burst_busy);
    zq_len <= (zq_busy && !zq_prev) ? 1 : zq_len + int'(zq_busy);
    n_zqu <= n_zqu + int'(zq_update);
    if (n_cyc == 60000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // A burst of n link clocks, allowing for the synchroniser delay at each end.
  function automatic logic ok_len(input int x, input int n);
    return x >= (n - 1) * CK_DIV - 2 && x <= n * CK_DIV + 2;
  endfunction : ok_len

  // One request, judged for refusal, then waits until the controller is ready again.
  task automatic send(input dcd_cmd_t c, input logic [2:0] b, input logic [13:0] a, input logic bad);
    int k;
    k = 0;
    @(posedge clk);
    req_cmd <= c;
    req_ba <= b;
    req_addr <= a;
    req_valid <= 1'b1;
    do @(negedge clk); while (req_ready !== 1'b1 && ++k < 9000);
    @(posedge clk);
    req_valid <= 1'b0;
    #1 err = req_error;
    @(posedge clk);
    #1 err = err | req_error;
    chk("req_error", 16'(bad), 16'(err));
    do @(negedge clk); while (req_ready !== 1'b1 && ++k < 18000);
    repeat (16) @(negedge clk);
  endtask : send

  task automatic t_mrs();
    for (int i = 0; i < NMR; i++)
    begin
      send(CMD_MRS, i[2:0], 14'h0101 + 14'(i), 1'b0);
      chk("mode_reg", 16'(14'h0101 + 14'(i)), 16'(mode_regs[i*ADDR_W +: ADDR_W]));
    end
    send(CMD_MRS, 3'h4, 14'h0105, 1'b0);
    chk("mode_reg0", 16'h0105, 16'(mode_regs[ADDR_W-1:0]));
  endtask : t_mrs

  task automatic t_read();
    send(CMD_ACT, 3'h5, 14'h1234, 1'b0);
    chk("bank_open", 16'h0020, 16'(bank_open));
    chk("banks_open", 16'h0020, 16'(c_banks));
    send(CMD_ACT, 3'h5, 14'h0777, 1'b1);
    send(CMD_RD, 3'h5, 14'h0006, 1'b0);
    chk("rd_bank_col", 16'h0056, 16'({rd_bank, 1'b0, rd_col}));
    chk("rd_bc4_ap", 16'h0002, 16'({rd_bc4, rd_ap}));
    chk("bc4_len", 16'h0001, 16'(ok_len(busy_len, BC4_CK)));
    chk("bank_kept", 16'h0020, 16'(bank_open));
    send(CMD_RD, 3'h5, 14'h1403, 1'b0);
    chk("rd_col", 16'h0003, 16'(rd_col));
    chk("rd_bc4_ap", 16'h0001, 16'({rd_bc4, rd_ap}));
    chk("bl8_len", 16'h0001, 16'(ok_len(busy_len, BL8_CK)));
    chk("bank_auto_pre", 16'h0000, 16'(bank_open));
    chk("idle", 16'h0001, 16'(idle));
    send(CMD_MRS, 3'h0, 14'h0102, 1'b0);
    send(CMD_ACT, 3'h5, 14'h0001, 1'b0);
    send(CMD_RD, 3'h5, 14'h1000, 1'b0);
    chk("rd_fixed_bc4", 16'h0001, 16'(rd_bc4));
    send(CMD_PRE, 3'h5, 14'h0000, 1'b0);
    send(CMD_RD, 3'h2, 14'h0000, 1'b1);
    send(CMD_PDX, 3'h0, 14'h0000, 1'b1);
    send(CMD_SRX, 3'h0, 14'h0000, 1'b1);
  endtask : t_read

  task automatic t_power();
    send(CMD_ACT, 3'h1, 14'h0042, 1'b0);
    send(CMD_SRE, 3'h0, 14'h0000, 1'b1);
    send(CMD_PDE, 3'h0, 14'h0000, 1'b0);
    chk("pd_state", 16'(DCD_PWR_PD), 16'(pwr_state));
    chk("pd_active_idle", 16'h0002, 16'({pd_active, idle}));
    send(CMD_PDX, 3'h0, 14'h0000, 1'b0);
    chk("pd_exit", 16'(DCD_PWR_ACT), 16'(pwr_state));
    send(CMD_PRE, 3'h1, 14'h0000, 1'b0);
    send(CMD_PDE, 3'h0, 14'h0000, 1'b0);
    chk("pd_precharge", 16'h0004, 16'({pwr_state, pd_active, bank_open[0]}));
    send(CMD_PDX, 3'h0, 14'h0000, 1'b0);
    send(CMD_SRE, 3'h0, 14'h0000, 1'b0);
    chk("sr_state", 16'(DCD_PWR_SR), 16'(pwr_state));
    chk("ctrl_sr_state", 16'(DCD_PWR_SR), 16'(c_pwr));
    send(CMD_SRX, 3'h0, 14'h0000, 1'b0);
    chk("sr_exit", 16'(DCD_PWR_ACT), 16'(pwr_state));
    chk("idle", 16'h0001, 16'(idle));
  endtask : t_power

  task automatic t_zq();
    send(CMD_ZQCS, 3'h0, 14'h0000, 1'b0);
    chk("zqcs_len", 16'h0001, 16'(zq_len > 0 && zq_len <= ZQCS_CK * CK_DIV));
    chk("zq_updates", 16'h0001, 16'(n_zqu));
    send(CMD_ZQCL, 3'h0, 14'h0400, 1'b0);
    chk("zqcl_len", 16'h0001, 16'(zq_len > ZQCS_CK * CK_DIV));
    chk("zq_updates", 16'h0002, 16'(n_zqu));
  endtask : t_zq

  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Reset for 16 cycles, then each scenario in turn.
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_mrs();
    t_read();
    t_power();
    t_zq();
    complete_run();
  end
endmodule : dcd_tb
